// >>> verilog/port_pkg.sv
// Constants, field layouts and carrier types shared by the parallel port front end.
package port_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned DELAY1_NS = 1000;
    localparam logic [7:0] DELAY1_RST = 8'((DELAY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] TDC0_RST = 8'h00;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [31:0] BLK_DMA = 32'h0010_1000;
    localparam logic [31:0] BLK_SLV = 32'h0010_2000;
    localparam logic [31:0] BLK_DRST = 32'h0010_3000;
    localparam logic [3:0][31:0] CHIP_BASE = {32'hf180_0000, 32'hf100_0000,
                                              32'hf080_0000, 32'hf000_0000};
    localparam logic [2:0] SLV_DATA = 3'h0;
    localparam logic [2:0] SLV_STATUS = 3'h1;
    localparam logic [2:0] SLV_DEVCTL = 3'h2;
    localparam logic [2:0] SLV_MODE = 3'h4;
    localparam logic [2:0] SLV_IECTL = 3'h5;
    localparam logic [2:0] SLV_TDC0 = 3'h6;
    localparam logic [2:0] SLV_DELAY1 = 3'h7;
    localparam int unsigned SLV_HI_BIT = 11;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int unsigned DC_STROBE = 0;
    localparam int unsigned DC_AUTOFD = 1;
    localparam int unsigned DC_INIT = 2;
    localparam int unsigned DC_SLIN = 3;
    localparam int unsigned DC_NWRRD = 5;
    localparam logic [5:0] DEVCTL_RST = 6'h03;
    localparam logic [7:0] DEVCTL_RD_ONES = 8'hc0;
    localparam int unsigned MC_BIDEN = 4;
    localparam int unsigned MC_MODE0 = 5;
    localparam int unsigned MC_MODE1 = 6;
    localparam logic [7:0] MODE_WMASK = 8'hf8;
    localparam logic [7:0] IECTL_WMASK = 8'hbf;
    localparam logic [7:0] STATUS_ONES = 8'h07;

    // ----------------------------------------------------------------
    // Data path
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 8;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } host_req_t;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_SETUP = 4'b0010,
        HS_PULSE = 4'b0100,
        HS_WAIT = 4'b1000
    } hs_state_t;
endpackage : port_pkg

// >>> verilog/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_reg != '0) && !flush;
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                count_reg <= '0;
            end else begin
                if (push) begin
                    wr_ptr_reg <= bump(wr_ptr_reg);
                end
                if (pop) begin
                    rd_ptr_reg <= bump(rd_ptr_reg);
                end
                if (push && !pop) begin
                    count_reg <= count_reg + (AW+1)'(1);
                end else if (pop && !push) begin
                    count_reg <= count_reg - (AW+1)'(1);
                end
            end
        end
    end
endmodule : byte_fifo
`default_nettype wire

// >>> verilog/par_port.sv
// Parallel port front end: block decode, lane routing, reset state and output handshake.
`timescale 1ns/1ps
`default_nettype none
module par_port (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [1:0] space_sel,
    input wire port_pkg::host_req_t host_req,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    output logic host_wr_ready,
    input wire logic dma_active,
    input wire logic dma_valid,
    input wire logic [7:0] dma_data,
    output logic dma_ready,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic pd_oe,
    output logic strobe_line,
    output logic autofeed_direction_line,
    output logic init_line,
    output logic select_in_line,
    input wire logic busy_line,
    input wire logic ack_n_line,
    input wire logic paper_end_line,
    input wire logic select_line,
    input wire logic error_n_line
);
    // ----------------------------------------------------------------
    // Block decode
    // ----------------------------------------------------------------
    function automatic logic block_hit(input logic [31:0] a, input logic [31:0] chip,
                                       input logic [31:0] blk);
        logic [31:0] b;
        b = chip | blk;
        return a[31:12] == b[31:12];
    endfunction : block_hit

    logic [31:0] chip;
    logic hit_slv;
    logic hit_dma;
    logic hit_drst;
    logic slv_hi;
    logic soft_rst;
    logic dma_rst;
    logic [7:0] slv_wr;
    logic [7:0] slv_wd [8];
    logic [3:0] dma_wr;

    assign chip = port_pkg::CHIP_BASE[space_sel];
    assign hit_slv = block_hit(host_req.addr, chip, port_pkg::BLK_SLV);
    assign hit_dma = block_hit(host_req.addr, chip, port_pkg::BLK_DMA);
    assign hit_drst = block_hit(host_req.addr, chip, port_pkg::BLK_DRST);
    assign slv_hi = host_req.addr[port_pkg::SLV_HI_BIT];
    assign soft_rst = ce && host_req.wr && hit_slv && !slv_hi && (|host_req.be);
    assign dma_rst = ce && host_req.wr && hit_drst && (|host_req.be);

    // Each lane lands on the register at its own byte address: sparse decode means
    // bit 2 of the word address plus the lane picks one of eight slave registers.
    always_comb begin
        slv_wr = '0;
        dma_wr = '0;
        slv_wd = '{default: 8'h00};
        for (int i = 0; i < 4; i++) begin
            if (ce && host_req.wr && host_req.be[i]) begin
                if (hit_slv && slv_hi) begin
                    slv_wr[{host_req.addr[2], 2'(i)}] = 1'b1;
                    slv_wd[{host_req.addr[2], 2'(i)}] = host_req.wdata[8*i +: 8];
                end
                if (hit_dma) begin
                    dma_wr[i] = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Slave registers
    // ----------------------------------------------------------------
    logic [5:0] devctl_reg;
    logic [7:0] mode_reg;
    logic [7:0] iectl_reg;
    logic [7:0] tdc0_reg;
    logic [7:0] second_timing_delay_counter_reg;
    logic out_dir;

    // Status (index 1) and the unused index 3 get a write strobe from the decode, but no register uses it.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            devctl_reg <= port_pkg::DEVCTL_RST;
        end else if (soft_rst) begin
            devctl_reg[5:4] <= '0;
        end else if (slv_wr[port_pkg::SLV_DEVCTL]) begin
            devctl_reg <= slv_wd[port_pkg::SLV_DEVCTL][5:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= '0;
            iectl_reg <= '0;
            tdc0_reg <= port_pkg::TDC0_RST;
            second_timing_delay_counter_reg <= port_pkg::DELAY1_RST;
        end else if (soft_rst) begin
            mode_reg <= '0;
            iectl_reg <= '0;
            tdc0_reg <= port_pkg::TDC0_RST;
            second_timing_delay_counter_reg <= port_pkg::DELAY1_RST;
        end else begin
            if (slv_wr[port_pkg::SLV_MODE]) begin
                mode_reg <= slv_wd[port_pkg::SLV_MODE] & port_pkg::MODE_WMASK;
            end
            if (slv_wr[port_pkg::SLV_IECTL]) begin
                iectl_reg <= slv_wd[port_pkg::SLV_IECTL] & port_pkg::IECTL_WMASK;
            end
            if (slv_wr[port_pkg::SLV_TDC0]) begin
                tdc0_reg <= slv_wd[port_pkg::SLV_TDC0];
            end
            if (slv_wr[port_pkg::SLV_DELAY1]) begin
                second_timing_delay_counter_reg <= slv_wd[port_pkg::SLV_DELAY1];
            end
        end
    end

    assign out_dir = !mode_reg[port_pkg::MC_BIDEN] || !devctl_reg[port_pkg::DC_NWRRD];

    // ----------------------------------------------------------------
    // DMA registers, aliased by lane
    // ----------------------------------------------------------------
    logic [7:0] dma_reg [4];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dma_reg <= '{default: 8'h00};
        end else if (dma_rst || soft_rst) begin
            dma_reg <= '{default: 8'h00};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (dma_wr[i]) begin
                    dma_reg[i] <= host_req.wdata[8*i +: 8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Outbound FIFO
    // ----------------------------------------------------------------
    logic host_push;
    logic fifo_in_valid;
    logic [7:0] fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;

    // Host data writes are dropped while DMA owns the port; a full FIFO also drops
    // them, so software should watch host_wr_ready before each byte.
    assign host_push = slv_wr[port_pkg::SLV_DATA] && !dma_active && out_dir;
    assign fifo_in_valid = dma_active ? dma_valid : host_push;
    assign fifo_in_data = dma_active ? dma_data : slv_wd[port_pkg::SLV_DATA];
    assign dma_ready = dma_active && fifo_in_ready;
    assign host_wr_ready = !dma_active && fifo_in_ready;

    byte_fifo #(.WIDTH(port_pkg::DATA_W), .DEPTH(port_pkg::FIFO_DEPTH)) byte_fifo_i (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .flush(soft_rst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop)
    );

    // ----------------------------------------------------------------
    // Output handshake engine
    // ----------------------------------------------------------------
    port_pkg::hs_state_t hs_reg;
    logic [7:0] cnt_reg;
    logic [7:0] pd_out_reg;
    logic ack_seen_reg;
    logic use_ack;
    logic use_busy;
    logic hs_done;

    assign fifo_pop = (hs_reg == port_pkg::HS_IDLE) && out_dir && !soft_rst;
    assign use_ack = mode_reg[port_pkg::MC_MODE0] || !mode_reg[port_pkg::MC_MODE1];
    assign use_busy = mode_reg[port_pkg::MC_MODE1];
    assign hs_done = (!use_ack || ack_seen_reg) && (!use_busy || !busy_line);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hs_reg <= port_pkg::HS_IDLE;
            cnt_reg <= '0;
        end else if (soft_rst) begin
            hs_reg <= port_pkg::HS_IDLE;
            cnt_reg <= '0;
        end else if (ce) begin
            case (hs_reg)
                port_pkg::HS_IDLE: begin
                    if (fifo_pop && fifo_out_valid) begin
                        hs_reg <= port_pkg::HS_SETUP;
                        cnt_reg <= second_timing_delay_counter_reg;
                    end
                end
                port_pkg::HS_SETUP: begin
                    if (cnt_reg == 8'h00) begin
                        hs_reg <= port_pkg::HS_PULSE;
                        cnt_reg <= second_timing_delay_counter_reg;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                port_pkg::HS_PULSE: begin
                    if (cnt_reg == 8'h00) begin
                        hs_reg <= port_pkg::HS_WAIT;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                port_pkg::HS_WAIT: begin
                    if (hs_done) begin
                        hs_reg <= port_pkg::HS_IDLE;
                    end
                end
                default: begin
                    hs_reg <= port_pkg::HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pd_out_reg <= '0;
            ack_seen_reg <= 1'b0;
        end else if (ce) begin
            if (fifo_pop && fifo_out_valid) begin
                pd_out_reg <= fifo_out_data;
            end
            if (hs_reg == port_pkg::HS_IDLE || soft_rst) begin
                ack_seen_reg <= 1'b0;
            end else if (!ack_n_line) begin
                ack_seen_reg <= 1'b1;
            end
        end
    end

    assign pd_out = pd_out_reg;
    assign pd_oe = out_dir;
    assign strobe_line = devctl_reg[port_pkg::DC_STROBE] && (hs_reg != port_pkg::HS_PULSE);
    assign autofeed_direction_line = devctl_reg[port_pkg::DC_AUTOFD];
    assign init_line = devctl_reg[port_pkg::DC_INIT];
    assign select_in_line = devctl_reg[port_pkg::DC_SLIN];

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] slv_rd [8];
    logic [31:0] rdata_next;

    always_comb begin
        slv_rd[port_pkg::SLV_DATA] = out_dir ? pd_out_reg : pd_in;
        slv_rd[port_pkg::SLV_STATUS] = {!busy_line, ack_n_line, paper_end_line, select_line,
                                        error_n_line, 3'b000} | port_pkg::STATUS_ONES;
        slv_rd[port_pkg::SLV_DEVCTL] = {2'b00, devctl_reg} | port_pkg::DEVCTL_RD_ONES;
        slv_rd[3] = 8'h00;
        slv_rd[port_pkg::SLV_MODE] = mode_reg;
        slv_rd[port_pkg::SLV_IECTL] = iectl_reg;
        slv_rd[port_pkg::SLV_TDC0] = tdc0_reg;
        slv_rd[port_pkg::SLV_DELAY1] = second_timing_delay_counter_reg;
        rdata_next = '0;
        for (int i = 0; i < 4; i++) begin
            if (hit_slv && slv_hi) begin
                rdata_next[8*i +: 8] = slv_rd[{host_req.addr[2], 2'(i)}];
            end else if (hit_dma) begin
                rdata_next[8*i +: 8] = dma_reg[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            host_rdata <= '0;
            host_rvalid <= 1'b0;
        end else if (ce) begin
            host_rvalid <= host_req.rd;
            if (host_req.rd) begin
                host_rdata <= rdata_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence seq_strobe_start;
        ce && hs_reg == port_pkg::HS_SETUP && cnt_reg == 8'h00 && !soft_rst;
    endsequence
    sequence seq_wait_done;
        ce && hs_reg == port_pkg::HS_WAIT && hs_done && !soft_rst;
    endsequence

    chk_strobe_low_pulse: assert property (seq_strobe_start |=> !strobe_line)
        else $error("strobe not driven low after setup");
    chk_done_to_idle: assert property (seq_wait_done |=> hs_reg == port_pkg::HS_IDLE)
        else $error("handshake did not finish on completion");
    chk_soft_keeps_lines: assert property (soft_rst |=> $stable(devctl_reg[3:0]))
        else $error("directed reset changed output lines");
    chk_soft_tdc_load: assert property (soft_rst |=>
        second_timing_delay_counter_reg == port_pkg::DELAY1_RST)
        else $error("delay counter not loaded with one microsecond");
    chk_soft_irq_off: assert property (soft_rst |=> iectl_reg == 8'h00)
        else $error("interrupt enables survived reset");
    chk_soft_sm_idle: assert property (soft_rst |=> hs_reg == port_pkg::HS_IDLE)
        else $error("state machine not idle after reset");
    chk_dma_data_block: assert property (ce && dma_active && !dma_valid
        && slv_wr[port_pkg::SLV_DATA] |-> !fifo_in_valid)
        else $error("host data write taken during DMA");
    chk_devctl_lane: assert property (ce && host_req.wr && hit_slv && slv_hi
        && !soft_rst && !host_req.addr[2] && host_req.be[2]
        |=> devctl_reg == $past(host_req.wdata[21:16]))
        else $error("lane 2 did not reach device control");
    chk_dma_page_lane: assert property (ce && host_req.wr && hit_dma && !dma_rst
        && !soft_rst && host_req.be[3] |=> dma_reg[3] == $past(host_req.wdata[31:24]))
        else $error("lane 3 did not reach address high page");
    chk_unused_lane: assert property (ce && host_req.wr && hit_slv && slv_hi
        && !host_req.addr[2] && !host_req.be[0] && !host_req.be[2]
        |=> $stable(devctl_reg) && $stable(mode_reg))
        else $error("write to unmapped lane changed state");
endmodule : par_port
`default_nettype wire

// >>> verif/printer_model.sv
// Behavioural printer that takes strobed bytes and answers with busy and ack.
`timescale 1ns/1ps
`default_nettype none
module printer_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic reply_en,
    input wire logic [7:0] reply,
    input wire logic strobe_line,
    input wire logic pd_oe,
    input wire logic [7:0] pd_out,
    output logic [7:0] pd_in,
    output logic [7:0] got_byte,
    output logic busy_line,
    output logic ack_n_line
);
    logic strobe_reg;
    logic [4:0] cnt_reg;
    // Undriven lines sit at the pull-up level, never at a stale byte.
    assign pd_in = pd_oe ? pd_out : (reply_en ? reply : 8'hff);
    // Ack falls late in the busy period, so every completion mode can finish.
    assign busy_line = cnt_reg != 5'h00;
    assign ack_n_line = !(cnt_reg == 5'h03 || cnt_reg == 5'h02);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strobe_reg <= 1'b1;
            cnt_reg <= 5'h00;
            got_byte <= 8'h00;
        end else begin
            strobe_reg <= strobe_line;
            if (strobe_reg && !strobe_line && cnt_reg == 5'h00) begin
                got_byte <= pd_in;
                cnt_reg <= slow ? 5'h14 : 5'h05;
            end else if (cnt_reg != 5'h00) begin
                cnt_reg <= cnt_reg - 5'h01;
            end
        end
    end
endmodule : printer_model
`default_nettype wire

// >>> verif/par_port_test.sv
// Self-checking bench for the parallel port front end.
`timescale 1ns/1ps
`default_nettype none
module par_port_test;
    localparam logic [31:0] SLV = port_pkg::BLK_SLV;
    localparam logic [31:0] DMA = port_pkg::BLK_DMA;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [1:0] space_sel = 2'h0;
    port_pkg::host_req_t host_req = '0;
    logic dma_active = 1'b0;
    logic dma_valid = 1'b0;
    logic [7:0] dma_data = 8'h00;
    logic slow = 1'b0;
    logic reply_en = 1'b0;
    logic [7:0] reply = 8'h00;
    logic [31:0] host_rdata;
    logic host_rvalid, host_wr_ready, dma_ready, pd_oe, strobe_line, busy_line, ack_n_line;
    logic autofeed_direction_line, init_line, select_in_line;
    logic [7:0] pd_in, pd_out, got_byte;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    par_port par_port_i (.core_clk, .rstn, .ce, .space_sel, .host_req, .host_rdata,
        .host_rvalid, .host_wr_ready, .dma_active, .dma_valid, .dma_data, .dma_ready, .pd_in,
        .pd_out, .pd_oe, .strobe_line, .autofeed_direction_line, .init_line, .select_in_line,
        .busy_line, .ack_n_line, .paper_end_line(1'b0), .select_line(1'b1),
        .error_n_line(1'b1));
    printer_model printer_model_i (.core_clk, .rstn, .slow, .reply_en, .reply, .strobe_line,
        .pd_oe, .pd_out, .pd_in, .got_byte, .busy_line, .ack_n_line);

    always #12.5 core_clk = ~core_clk;

    // --------------------
    // Shared tasks
    // --------------------
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [31:0] off, input logic [3:0] be,
            input logic [31:0] wd);
        @(negedge core_clk);
        host_req = '{addr: port_pkg::CHIP_BASE[space_sel] | off, be: be, wdata: wd,
            wr: wr, rd: !wr};
        @(negedge core_clk);
        host_req = '0;
    endtask : bus

    // Single-byte accesses keep neighbouring registers untouched.
    task automatic wr8(input logic [31:0] off, input logic [7:0] v);
        bus(1'b1, off, 4'h1 << off[1:0], {4{v}});
    endtask : wr8

    task automatic rd8(input logic [31:0] off, input logic [7:0] exp, input string what);
        bus(1'b0, off, 4'h1 << off[1:0], 32'h0000_0000);
        chk(what, {1'b1, exp}, {host_rvalid, host_rdata[8*off[1:0] +: 8]});
    endtask : rd8

    task automatic wait_for(input int sel, input logic lvl, input string what);
        int n;
        n = 0;
        while ((sel == 0 ? strobe_line : busy_line) !== lvl && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        chk(what, lvl, sel == 0 ? strobe_line : busy_line);
    endtask : wait_for

    task automatic send_check(input logic [7:0] v);
        wait_for(0, 1'b0, "strobe_low");
        chk("pd_out", v, pd_out);
        chk("pd_oe", 1'b1, pd_oe);
        wait_for(0, 1'b1, "strobe_high");
        wait_for(1, 1'b0, "busy_low");
        chk("got_byte", v, got_byte);
        repeat (4) @(negedge core_clk);
    endtask : send_check

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        chk("strobe_line", 1'b1, strobe_line);
        chk("autofeed", 1'b1, autofeed_direction_line);
        chk("init_line", 1'b0, init_line);
        chk("select_in", 1'b0, select_in_line);
        rd8(SLV | 32'h801, 8'hdf, "status");
        rd8(SLV | 32'h804, 8'h00, "mode");
        rd8(SLV | 32'h805, 8'h00, "iectl");
        rd8(SLV | 32'h807, port_pkg::DELAY1_RST, "delay1");
        $display("test reset done");
    endtask : t_reset

    task automatic t_word();
        logic [1:0] m;
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 2'h0 : 2'(i + 1);
            slow = m[0];
            wr8(SLV | 32'h804, {1'b0, m, 5'h00});
            bus(1'b1, SLV | 32'h800, 4'hf, {8'hff, 5'h00, m[1], 2'h3, 8'h00, 8'h50 + 8'(i)});
            send_check(8'h50 + 8'(i));
            chk("init_line", m[1], init_line);
            rd8(SLV | 32'h802, {5'h18, m[1], 2'h3}, "devctl");
        end
        $display("test word done");
    endtask : t_word

    task automatic t_input();
        wr8(SLV | 32'h804, 8'h10);
        wr8(SLV | 32'h802, 8'h23);
        reply = 8'ha6;
        reply_en = 1'b1;
        @(negedge core_clk);
        chk("pd_oe_in", 1'b0, pd_oe);
        rd8(SLV | 32'h800, 8'ha6, "data_in");
        reply_en = 1'b0;
        wr8(SLV | 32'h802, 8'h03);
        wr8(SLV | 32'h804, 8'h00);
        $display("test input done");
    endtask : t_input

    task automatic t_dma();
        int n;
        dma_active = 1'b1;
        @(negedge core_clk);
        chk("host_wr_ready", 1'b0, host_wr_ready);
        wr8(SLV | 32'h800, 8'h77);
        dma_data = 8'h3c;
        dma_valid = 1'b1;
        n = 0;
        while (dma_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        dma_valid = 1'b0;
        send_check(8'h3c);
        rd8(SLV | 32'h800, 8'h3c, "data_rd_dma");
        dma_active = 1'b0;
        $display("test dma done");
    endtask : t_dma

    task automatic t_dmaregs();
        bus(1'b1, DMA | 32'h400, 4'hf, 32'h4433_2211);
        for (int i = 0; i < 4; i++) begin
            rd8(DMA | 32'(i), 8'h11 * 8'(i + 1), "dma_reg");
        end
        wr8(port_pkg::BLK_DRST, 8'h5a);
        rd8(DMA | 32'h001, 8'h00, "dma_clear");
        $display("test dma registers done");
    endtask : t_dmaregs

    task automatic t_space();
        for (int s = 0; s < 4; s++) begin
            space_sel = 2'(s);
            wr8(SLV | 32'h807, 8'h10 + 8'(s));
            wr8(SLV | 32'h0400_0807, 8'hee);
            rd8(SLV | 32'h807, 8'h10 + 8'(s), "delay1_space");
        end
        space_sel = 2'h0;
        wr8(SLV | 32'h803, 8'hff);
        rd8(SLV | 32'h802, 8'hc3, "devctl_kept");
        ce = 1'b0;
        wr8(SLV | 32'h802, 8'h00);
        ce = 1'b1;
        rd8(SLV | 32'h802, 8'hc3, "devctl_frozen");
        $display("test space done");
    endtask : t_space

    task automatic t_direct();
        wr8(SLV | 32'h802, 8'h0d);
        wr8(SLV | 32'h807, 8'h05);
        wr8(SLV | 32'h804, 8'h10);
        wr8(SLV | 32'h805, 8'hff);
        wr8(SLV | 32'h000, 8'h00);
        chk("strobe_kept", 1'b1, strobe_line);
        chk("autofeed_kept", 1'b0, autofeed_direction_line);
        chk("init_kept", 1'b1, init_line);
        chk("select_in_kept", 1'b1, select_in_line);
        rd8(SLV | 32'h807, port_pkg::DELAY1_RST, "delay1_rst");
        rd8(SLV | 32'h805, 8'h00, "iectl_rst");
        rd8(SLV | 32'h804, 8'h00, "mode_rst");
        $display("test directed reset done");
    endtask : t_direct

    initial begin
        repeat (9) @(negedge core_clk);
        rstn = 1'b1;
        t_reset();
        t_word();
        t_input();
        t_dma();
        t_dmaregs();
        t_space();
        t_direct();
        give_verdict();
    end
endmodule : par_port_test
`default_nettype wire
